// ---- design/comparator_pkg.sv ----
// Shared constants, types and register map for the comparator control block.
// Assumes a 32-bit APB master on the same clock as the block.
package comparator_pkg;

	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int LEVEL_W = 10;
	localparam int CHAN_N = 8;
	localparam int CHAN_W = 3;

	// ----------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [ADDR_W-1:0] CTRL_STATUS_OFS = 8'h30;
	localparam logic [ADDR_W-1:0] CONV_CTRL_B_OFS = 8'h34;
	localparam logic [ADDR_W-1:0] PIN_DISABLE_OFS = 8'h38;
	localparam logic [ADDR_W-1:0] IRQ_STATUS_OFS = 8'h3c;
	localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 8'h40;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int POWER_OFF_BIT = 7;
	localparam int BANDGAP_BIT = 6;
	localparam int RESULT_BIT = 5;
	localparam int FLAG_BIT = 4;
	localparam int IRQ_EN_BIT = 3;
	localparam int CAPTURE_BIT = 2;
	localparam int MODE_LSB = 0;
	localparam int MUX_EN_BIT = 6;
	localparam int NEG_PIN_OFF_BIT = 1;
	localparam int POS_PIN_OFF_BIT = 0;
	localparam int EVENT_STAT_BIT = 0;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [1:0] MODE_RESET = 2'h0;
	localparam logic [1:0] PIN_OFF_RESET = 2'h0;
	localparam logic IRQ_BIT_RESET = 1'b0;
	localparam logic [DATA_W-1:0] RDATA_RESET = 32'h0000_0000;

	// ----------------------------------------
	// Enumerations
	// ----------------------------------------
	typedef enum logic [1:0]
	{
		MODE_TOGGLE = 2'h0,
		MODE_RESERVED = 2'h1,
		MODE_FALL = 2'h2,
		MODE_RISE = 2'h3
	} event_mode_t;

	typedef enum logic [1:0]
	{
		APB_IDLE = 2'h1,
		APB_RESP = 2'h2
	} apb_state_t;

	// ----------------------------------------
	// Bus carriers
	// ----------------------------------------
	typedef struct packed
	{
		logic psel;
		logic penable;
		logic pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [DATA_W-1:0] pwdata;
	} apb_req_t;

	typedef struct packed
	{
		logic pready;
		logic pslverr;
		logic [DATA_W-1:0] prdata;
	} apb_rsp_t;

endpackage

// ---- design/level_sync.sv ----
// Two-stage synchroniser for levels arriving from outside the clock domain.
// Assumes the source holds each level for at least two clock periods.
`timescale 1ns/10ps
module level_sync
	import comparator_pkg::*;
#(
	parameter int WIDTH = 1
)
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Levels
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_r;

	// ----------------------------------------
	// First stage read only by second stage
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meta_r <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta_r <= async_in;
			sync_out <= meta_r;
		end
	end

endmodule

// ---- design/edge_detect.sv ----
// Rising and falling detector on a synchronised level.
// Assumes the level is already in the pclk domain.
`timescale 1ns/10ps
module edge_detect
	import comparator_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Level and edges
	input wire logic level,
	output logic rise,
	output logic fall
);

	logic prev_r;

	// ----------------------------------------
	// Value one clock earlier
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prev_r <= 1'b0;
		else
			prev_r <= level;
	end

	assign rise = level && !prev_r;
	assign fall = !level && prev_r;

endmodule

// ---- design/comparator_ctrl.sv ----
// Digital control around the on-chip analog comparator: input selection,
// result synchronisation, event detection, flag and interrupt, capture route,
// pin input disable, and an APB register slave.
// Assumes analog levels arrive as unsigned codes and converter state is on pclk.
//
// Overview of operation
// - Raw result is high when selected positive level exceeds selected negative level.
// - Negative side uses converter channel 0..7 when mux enabled and converter off.
// - Bandgap select replaces the positive pin by the fixed reference.
// - Readable result bit is the raw result after a two-flop synchroniser.
// - Mode 00 toggle, 01 reserved, 10 falling edge, 11 rising edge.
// - A matching result event sets the event flag, bit 4.
// - Flag clears on vector acknowledge or on writing one to it.
// - Interrupt request while flag, enable bit 3 and global enable are set.
// - Capture route bit 2 passes the result to timer capture front end.
// - Power-off bit 7 switches the comparator off at any time.
// - Each pin disable bit turns off its input buffer, pin reads zero.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/10ps
module comparator_ctrl
	import comparator_pkg::*;
#(
	parameter logic [LEVEL_W-1:0] BANDGAP_LEVEL = 10'h1c2
)
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire apb_req_t apb_req,
	output apb_rsp_t apb_rsp,
	// Analog levels as codes
	input wire logic [LEVEL_W-1:0] positive_input_pin,
	input wire logic [LEVEL_W-1:0] negative_input_pin,
	input wire logic [CHAN_N-1:0][LEVEL_W-1:0] converter_input_pins,
	// Converter state
	input wire logic converter_enable,
	input wire logic [CHAN_W-1:0] converter_channel_select,
	// Core interrupt handshake
	input wire logic global_irq_enable,
	input wire logic irq_vector_taken,
	// Digital pin levels
	input wire logic [1:0] pin_digital_in,
	// Outputs to the device
	output logic comparator_result_raw,
	output logic comparator_powered,
	output logic capture_trigger,
	output logic comparator_irq_req,
	output logic irq,
	output logic [1:0] pin_read,
	output logic [1:0] pin_buffer_enable
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed
	{
		apb_state_t apb_state;
		apb_rsp_t rsp;
		logic power_off;
		logic bandgap_select;
		logic event_flag;
		logic irq_enable;
		logic capture_route;
		logic [1:0] event_mode;
		logic mux_enable;
		logic [1:0] pin_off;
		logic event_status;
		logic event_mask;
		logic irq;
		logic cmp_irq;
		logic capture;
		logic raw;
		logic [1:0] pin_read;
		logic [1:0] buf_en;
		logic powered;
	} state_t;

	state_t st_r;
	state_t st_nxt;

	// ----------------------------------------
	// Analog input selection
	// ----------------------------------------
	logic [LEVEL_W-1:0] pos_level;
	logic [LEVEL_W-1:0] neg_level;
	logic use_conv_mux;
	logic cmp_raw;

	always_comb
	begin
		use_conv_mux = st_r.mux_enable && !converter_enable;
		pos_level = st_r.bandgap_select ? BANDGAP_LEVEL : positive_input_pin;
		neg_level = use_conv_mux ? converter_input_pins[converter_channel_select] : negative_input_pin;
		cmp_raw = !st_r.power_off && (pos_level > neg_level);
	end

	// ----------------------------------------
	// Synchronisers and edge detection
	// ----------------------------------------
	logic result_sync;
	logic [1:0] pin_sync;
	logic res_rise;
	logic res_fall;

	level_sync #(.WIDTH(1)) u_result_sync
	(
		.pclk(pclk),
		.presetn(presetn),
		.async_in(cmp_raw),
		.sync_out(result_sync)
	);

	level_sync #(.WIDTH(2)) u_pin_sync
	(
		.pclk(pclk),
		.presetn(presetn),
		.async_in(pin_digital_in),
		.sync_out(pin_sync)
	);

	edge_detect u_edge
	(
		.pclk(pclk),
		.presetn(presetn),
		.level(result_sync),
		.rise(res_rise),
		.fall(res_fall)
	);

	// ----------------------------------------
	// Event selection
	// ----------------------------------------
	logic event_hit;

	always_comb
	begin
		case (event_mode_t'(st_r.event_mode))
			MODE_TOGGLE: event_hit = res_rise || res_fall;
			MODE_FALL: event_hit = res_fall;
			MODE_RISE: event_hit = res_rise;
			default: event_hit = 1'b0;
		endcase
	end

	// ----------------------------------------
	// Register decode
	// ----------------------------------------
	logic access_start;
	logic access_done;
	logic wr_done;
	logic rd_done;
	logic addr_hit;
	logic [DATA_W-1:0] rd_value;
	logic [7:0] ctrl_view;

	always_comb
	begin
		access_start = apb_req.psel && apb_req.penable && (st_r.apb_state == APB_IDLE);
		access_done = apb_req.psel && apb_req.penable && (st_r.apb_state == APB_RESP);
		wr_done = access_done && apb_req.pwrite;
		rd_done = access_done && !apb_req.pwrite;
		ctrl_view = {st_r.power_off, st_r.bandgap_select, result_sync, st_r.event_flag,
			st_r.irq_enable, st_r.capture_route, st_r.event_mode};
		addr_hit = 1'b1;
		rd_value = RDATA_RESET;
		case (apb_req.paddr)
			CTRL_STATUS_OFS: rd_value[7:0] = ctrl_view;
			CONV_CTRL_B_OFS: rd_value[MUX_EN_BIT] = st_r.mux_enable;
			PIN_DISABLE_OFS: rd_value[1:0] = st_r.pin_off;
			IRQ_STATUS_OFS: rd_value[EVENT_STAT_BIT] = st_r.event_status;
			IRQ_MASK_OFS: rd_value[EVENT_STAT_BIT] = st_r.event_mask;
			default: addr_hit = 1'b0;
		endcase
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	logic flag_clear;
	logic status_clear;

	always_comb
	begin
		st_nxt = st_r;
		flag_clear = irq_vector_taken;
		// Clear only what the read reported, so a later event is kept
		status_clear = rd_done && (apb_req.paddr == IRQ_STATUS_OFS) && st_r.rsp.prdata[EVENT_STAT_BIT];

		// Bus handshake: one wait cycle, answer registered
		case (st_r.apb_state)
			APB_IDLE:
			begin
				if (access_start)
				begin
					st_nxt.apb_state = APB_RESP;
					st_nxt.rsp.pready = 1'b1;
					st_nxt.rsp.pslverr = !addr_hit;
					st_nxt.rsp.prdata = apb_req.pwrite ? RDATA_RESET : rd_value;
				end
			end
			APB_RESP:
			begin
				st_nxt.apb_state = APB_IDLE;
				st_nxt.rsp.pready = 1'b0;
				st_nxt.rsp.pslverr = 1'b0;
			end
			default:
			begin
				st_nxt.apb_state = APB_IDLE;
				st_nxt.rsp.pready = 1'b0;
				st_nxt.rsp.pslverr = 1'b0;
			end
		endcase

		// Register writes take effect on the completing edge
		if (wr_done)
		begin
			case (apb_req.paddr)
				CTRL_STATUS_OFS:
				begin
					st_nxt.power_off = apb_req.pwdata[POWER_OFF_BIT];
					st_nxt.bandgap_select = apb_req.pwdata[BANDGAP_BIT];
					st_nxt.irq_enable = apb_req.pwdata[IRQ_EN_BIT];
					st_nxt.capture_route = apb_req.pwdata[CAPTURE_BIT];
					st_nxt.event_mode = apb_req.pwdata[MODE_LSB +: 2];
					flag_clear = flag_clear || apb_req.pwdata[FLAG_BIT];
				end
				CONV_CTRL_B_OFS: st_nxt.mux_enable = apb_req.pwdata[MUX_EN_BIT];
				PIN_DISABLE_OFS: st_nxt.pin_off = apb_req.pwdata[1:0];
				IRQ_MASK_OFS: st_nxt.event_mask = apb_req.pwdata[EVENT_STAT_BIT];
				default: st_nxt.mux_enable = st_r.mux_enable;
			endcase
		end

		// Set wins over clear
		st_nxt.event_flag = event_hit || (st_r.event_flag && !flag_clear);
		st_nxt.event_status = event_hit || (st_r.event_status && !status_clear);

		// Registered outputs
		st_nxt.cmp_irq = st_nxt.event_flag && st_nxt.irq_enable && global_irq_enable;
		st_nxt.irq = st_nxt.event_status && st_nxt.event_mask;
		st_nxt.capture = st_r.capture_route && result_sync;
		st_nxt.raw = cmp_raw;
		st_nxt.pin_read = pin_sync & ~st_r.pin_off;
		st_nxt.buf_en = ~st_r.pin_off;
		st_nxt.powered = !st_nxt.power_off;
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_r.apb_state <= APB_IDLE;
			st_r.rsp.pready <= 1'b0;
			st_r.rsp.pslverr <= 1'b0;
			st_r.rsp.prdata <= RDATA_RESET;
			st_r.power_off <= 1'b0;
			st_r.bandgap_select <= 1'b0;
			st_r.event_flag <= 1'b0;
			st_r.irq_enable <= 1'b0;
			st_r.capture_route <= 1'b0;
			st_r.event_mode <= MODE_RESET;
			st_r.mux_enable <= 1'b0;
			st_r.pin_off <= PIN_OFF_RESET;
			st_r.event_status <= IRQ_BIT_RESET;
			st_r.event_mask <= IRQ_BIT_RESET;
			st_r.irq <= 1'b0;
			st_r.cmp_irq <= 1'b0;
			st_r.capture <= 1'b0;
			st_r.raw <= 1'b0;
			st_r.pin_read <= 2'h0;
			st_r.buf_en <= 2'h3;
			st_r.powered <= 1'b1;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign apb_rsp = st_r.rsp;
	assign comparator_result_raw = st_r.raw;
	assign comparator_powered = st_r.powered;
	assign capture_trigger = st_r.capture;
	assign comparator_irq_req = st_r.cmp_irq;
	assign irq = st_r.irq;
	assign pin_read = st_r.pin_read;
	assign pin_buffer_enable = st_r.buf_en;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_access_begin;
		apb_req.psel && apb_req.penable && !apb_rsp.pready;
	endsequence

	sequence s_answer;
		##1 apb_rsp.pready ##1 !apb_rsp.pready;
	endsequence

	apb_answer_a: assert property (s_access_begin |-> s_answer)
		else $error("APB answer not given after one wait cycle");

	result_sync_a: assert property (result_sync == $past(cmp_raw, 2))
		else $error("Result status not two clocks behind raw result");

	flag_set_a: assert property (event_hit |=> st_r.event_flag)
		else $error("Matching event did not set the flag");

	flag_ack_a: assert property (irq_vector_taken && !event_hit |=> !st_r.event_flag)
		else $error("Flag not cleared by vector acknowledge");

	reserved_mode_a: assert property (st_r.event_mode == MODE_RESERVED && !st_r.event_flag
		&& $stable(st_r.event_mode) |=> !st_r.event_flag)
		else $error("Reserved mode raised the flag");

	rise_mode_a: assert property (st_r.event_mode == MODE_RISE && !st_r.event_flag
		&& $fell(result_sync) |=> !st_r.event_flag)
		else $error("Falling edge raised flag in rising mode");

	irq_request_a: assert property (st_r.event_flag && st_r.irq_enable && global_irq_enable
		|=> comparator_irq_req || !st_r.event_flag || !st_r.irq_enable)
		else $error("Interrupt request missing while enabled");

	irq_off_a: assert property (!st_r.irq_enable ##1 !st_r.irq_enable |-> !comparator_irq_req)
		else $error("Interrupt request while disabled");

	capture_route_a: assert property (st_r.capture_route |=> capture_trigger == $past(result_sync))
		else $error("Capture trigger does not follow result");

	capture_off_a: assert property (!st_r.capture_route |=> !capture_trigger)
		else $error("Capture trigger driven while route is off");

	power_off_a: assert property (st_r.power_off |=> !comparator_result_raw)
		else $error("Raw result high while powered off");

	neg_select_a: assert property (st_r.mux_enable && !converter_enable && !st_r.power_off
		&& !st_r.bandgap_select |=> comparator_result_raw
		== ($past(positive_input_pin) > $past(converter_input_pins[converter_channel_select])))
		else $error("Negative input not taken from converter channel");

	bandgap_a: assert property (st_r.bandgap_select && !st_r.power_off && !use_conv_mux
		|=> comparator_result_raw == (BANDGAP_LEVEL > $past(negative_input_pin)))
		else $error("Bandgap not used as positive input");

	pin_read_a: assert property (st_r.pin_off[POS_PIN_OFF_BIT] |=> !pin_read[POS_PIN_OFF_BIT])
		else $error("Disabled positive pin reads one");

	pin_buf_a: assert property (st_r.pin_off[NEG_PIN_OFF_BIT] |=> !pin_buffer_enable[NEG_PIN_OFF_BIT])
		else $error("Disabled negative pin buffer still enabled");

	edge_seen_a: assert property ((result_sync != $past(result_sync))
		&& st_r.event_mode == MODE_TOGGLE |-> event_hit)
		else $error("Toggle not detected in the cycle of change");

endmodule

// ---- dv/core_irq_model.sv ----
// Core interrupt acknowledge model: takes the comparator vector after a short latency.
// Assumes the request is a level on pclk and the acknowledge is a one-cycle pulse.
`timescale 1ns/10ps
module core_irq_model
	import comparator_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Interrupt handshake
	input wire logic comparator_irq_req,
	input wire logic ack_enable,
	output logic irq_vector_taken
);
	logic [1:0] wait_r;

	// ----------------------------------------
	// Vector entry after four cycles of request
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wait_r <= 2'h0;
			irq_vector_taken <= 1'b0;
		end
		else
		begin
			irq_vector_taken <= 1'b0;
			if (comparator_irq_req && ack_enable)
			begin
				wait_r <= wait_r + 2'h1;
				if (wait_r == 2'h3)
				begin
					irq_vector_taken <= 1'b1;
				end
			end
			else
			begin
				wait_r <= 2'h0;
			end
		end
	end
endmodule

// ---- dv/tb_comparator_control_logic.sv ----
// Self-checking bench for the comparator control block.
// Assumes the APB slave answers with pready and the core model acknowledges vectors.
`timescale 1ns/10ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin bad_count++; $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module tb_comparator_control_logic
	import comparator_pkg::*;
;
	localparam logic [LEVEL_W-1:0] BG = 10'h155;
	logic pclk = 1'b0;
	logic presetn;
	apb_req_t req;
	apb_rsp_t rsp;
	logic [LEVEL_W-1:0] pos, neg;
	logic [CHAN_N-1:0][LEVEL_W-1:0] conv;
	logic ce, gie, ack_en, vec, raw, powered, capture, irq_req, irq;
	logic [CHAN_W-1:0] ch;
	logic [1:0] pins_in, pin_read, pbe, d;
	logic [31:0] rd;
	logic er, me;
	logic [7:0] v;
	integer seed = 32'h6f979078;
	int bad_count = 0;
	int tests_run = 0;
	int i, j, m, n;

	// ----------------------------------------
	// Clock, design and partner
	// ----------------------------------------
	always #2 pclk = ~pclk;

	comparator_ctrl #(.BANDGAP_LEVEL(BG)) uut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
		.positive_input_pin(pos), .negative_input_pin(neg), .converter_input_pins(conv),
		.converter_enable(ce), .converter_channel_select(ch), .global_irq_enable(gie),
		.irq_vector_taken(vec), .pin_digital_in(pins_in), .comparator_result_raw(raw),
		.comparator_powered(powered), .capture_trigger(capture), .comparator_irq_req(irq_req),
		.irq(irq), .pin_read(pin_read), .pin_buffer_enable(pbe));

	core_irq_model core (.pclk(pclk), .presetn(presetn), .comparator_irq_req(irq_req),
		.ack_enable(ack_en), .irq_vector_taken(vec));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic complete_run();
		if (bad_count == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
		int k;
		@(posedge pclk);
		req.psel <= 1'b1;
		req.penable <= 1'b0;
		req.pwrite <= wr;
		req.paddr <= a;
		req.pwdata <= wd;
		@(posedge pclk);
		req.penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge pclk);
			k++;
		end
		while (rsp.pready !== 1'b1 && k < 50);
		if (k >= 50)
			bad_count++;
		rd = rsp.prdata;
		er = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask

	function automatic logic exp_raw(input logic [7:0] c, input logic mx);
		logic [LEVEL_W-1:0] p, q;
		p = c[BANDGAP_BIT] ? BG : pos;
		q = (mx && !ce) ? conv[ch] : neg;
		return !c[POWER_OFF_BIT] && (p > q);
	endfunction

	task automatic level(input logic hi);
		pos <= hi ? 10'h3ff : 10'h000;
		neg <= hi ? 10'h000 : 10'h3ff;
		repeat (6) @(posedge pclk);
	endtask

	// ----------------------------------------
	// Watchdog
	// ----------------------------------------
	initial
	begin
		repeat (20000) @(posedge pclk);
		bad_count++;
		complete_run();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		presetn = 1'b0;
		req = '0;
		{pos, neg, conv, ce, ch, gie, ack_en, pins_in} = '0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		`CHK(pbe, 2'h3)
		for (i = 0; i < 5; i++)
		begin
			apb(1'b0, CTRL_STATUS_OFS + 8'(4 * i), 32'h0000_0000);
			`CHK(({er, rd}), 33'h0_0000_0000)
		end
		apb(1'b0, 8'h44, 32'h0000_0000);
		`CHK(({er, rd}), 33'h1_0000_0000)
		// Random input selection, bandgap and route, power-off every fourth pass; interrupt kept off
		for (i = 0; i < 40; i++)
		begin
			pos <= 10'($random(seed));
			neg <= 10'($random(seed));
			for (j = 0; j < CHAN_N; j++)
				conv[j] <= 10'($random(seed));
			ce <= 1'($random(seed));
			ch <= 3'($random(seed));
			me = 1'($random(seed));
			v = (8'($random(seed)) & 8'h44) | ((i % 4 == 3) ? 8'h80 : 8'h00);
			apb(1'b1, CONV_CTRL_B_OFS, 32'(me) << MUX_EN_BIT);
			apb(1'b1, CTRL_STATUS_OFS, 32'(v));
			repeat (6) @(posedge pclk);
			`CHK(raw, exp_raw(v, me))
			`CHK(powered, !v[7])
			`CHK(capture, v[2] & exp_raw(v, me))
			apb(1'b0, CTRL_STATUS_OFS, 32'h0000_0000);
			`CHK(({rd[7:5], rd[3:0]}), ({v[7:6], exp_raw(v, me), v[3:0]}))
		end
		for (i = 0; i < 8; i++)
		begin
			pins_in <= 2'($random(seed));
			d = i[1:0];
			apb(1'b1, PIN_DISABLE_OFS, 32'(d));
			repeat (4) @(posedge pclk);
			`CHK(pin_read, pins_in & ~d)
			`CHK(pbe, ~d)
			apb(1'b0, PIN_DISABLE_OFS, 32'h0000_0000);
			`CHK(rd[1:0], d)
		end
		apb(1'b1, CONV_CTRL_B_OFS, 32'h0000_0000);
		for (m = 0; m < 4; m++)
		begin
			v = 8'h10 | 8'(m);
			level(1'b0);
			apb(1'b1, CTRL_STATUS_OFS, 32'(v));
			apb(1'b0, IRQ_STATUS_OFS, 32'h0000_0000);
			level(1'b1);
			apb(1'b0, CTRL_STATUS_OFS, 32'h0000_0000);
			`CHK(rd[4], 1'(m == 0 || m == 3))
			apb(1'b1, CTRL_STATUS_OFS, 32'(v));
			apb(1'b0, CTRL_STATUS_OFS, 32'h0000_0000);
			`CHK(rd[4], 1'b0)
			level(1'b0);
			apb(1'b0, CTRL_STATUS_OFS, 32'h0000_0000);
			`CHK(rd[4], 1'(m == 0 || m == 2))
		end
		apb(1'b1, IRQ_MASK_OFS, 32'h0000_0001);
		apb(1'b1, CTRL_STATUS_OFS, 32'h0000_001b);
		apb(1'b0, IRQ_STATUS_OFS, 32'h0000_0000);
		gie <= 1'b1;
		level(1'b1);
		`CHK(irq_req, 1'b1)
		`CHK(irq, 1'b1)
		gie <= 1'b0;
		repeat (3) @(posedge pclk);
		`CHK(irq_req, 1'b0)
		gie <= 1'b1;
		apb(1'b1, IRQ_MASK_OFS, 32'h0000_0000);
		repeat (2) @(posedge pclk);
		`CHK(irq, 1'b0)
		apb(1'b1, IRQ_MASK_OFS, 32'h0000_0001);
		apb(1'b0, IRQ_STATUS_OFS, 32'h0000_0000);
		`CHK(rd[0], 1'b1)
		apb(1'b0, IRQ_STATUS_OFS, 32'h0000_0000);
		`CHK(rd[0], 1'b0)
		`CHK(irq, 1'b0)
		ack_en <= 1'b1;
		n = 0;
		while (irq_req !== 1'b0 && n < 20)
		begin
			@(posedge pclk);
			n++;
		end
		ack_en <= 1'b0;
		apb(1'b0, CTRL_STATUS_OFS, 32'h0000_0000);
		`CHK(({irq_req, rd[4]}), 2'h0)
		apb(1'b1, CTRL_STATUS_OFS, 32'h0000_0003);
		level(1'b0);
		level(1'b1);
		`CHK(irq_req, 1'b0)
		apb(1'b0, CTRL_STATUS_OFS, 32'h0000_0000);
		`CHK(rd[4], 1'b1)
		complete_run();
	end
endmodule
